/* File: dv/usec_timer_bench.sv */
/*
 * Self-checking bench for the microsecond timer: reset values, staged
 * time writes, latched and live reads, pause, debug halt, alarms, irqs.
 * Assumes the design answers on AXI4-Lite and one 10 MHz clock.
 */
`timescale 1ns/100ps
module usec_timer_bench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic tick = 1'b0;
    logic [1:0] debug_active = 2'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    usec_timer_pkg::axi_addr_type s_axi_aw = '0;
    usec_timer_pkg::axi_wdata_type s_axi_w = '0;
    usec_timer_pkg::axi_addr_type s_axi_ar = '0;
    usec_timer_pkg::axi_rdata_type s_axi_r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp;
    logic [3:0] alarm_irq;
    logic [63:0] cnt = 64'h0000000000000000;
    logic [31:0] rdata, base;
    logic [1:0] resp;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int k;
    // ceiling well above the few hundred cycles the run needs
    localparam int LIMIT = 20000;

    // ****************************************
    // clock, design, hang guard
    // ****************************************
    always #50 clk = ~clk;

    usec_timer dut (.clk(clk), .reset(reset), .tick(tick), .debug_active(debug_active),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_aw(s_axi_aw),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_w(s_axi_w),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_ar(s_axi_ar),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_r(s_axi_r),
        .alarm_irq(alarm_irq));

    // a bus wait that never ends lands here
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count = bad_count + 1;
            print_verdict();
        end
    end

    // ****************************************
    // checks and bus tasks
    // ****************************************
    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task chk_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_resp

    function automatic logic [31:0] onehot(input int i);
        return 32'h00000001 << i;
    endfunction : onehot

    function automatic logic [6:0] tgt_off(input int i);
        return usec_timer_pkg::OFF_ALARM_TARGET_ZERO + 7'(4 * i);
    endfunction : tgt_off

    // ready is looked at on the falling edge, so the rising edge that
    // follows is the handshake edge without any race on comb readies
    task wr(input logic [6:0] off, input logic [31:0] d);
        logic aw_p, w_p, a, b, done;
        aw_p = 1'b1;
        w_p = 1'b1;
        done = 1'b0;
        s_axi_aw <= '{addr: usec_timer_pkg::TIMER_BASE_ADDR | {25'h0, off}, prot: 3'h0};
        s_axi_w <= '{data: d, strb: 4'hF};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_p || w_p) begin
            @(negedge clk);
            a = aw_p & s_axi_awready;
            b = w_p & s_axi_wready;
            @(posedge clk);
            if (a) s_axi_awvalid <= 1'b0;
            if (b) s_axi_wvalid <= 1'b0;
            aw_p = aw_p & ~a;
            w_p = w_p & ~b;
        end
        while (!done) begin
            @(negedge clk);
            done = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk);
        end
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask : wr

    task rd(input logic [6:0] off);
        logic done;
        done = 1'b0;
        s_axi_ar <= '{addr: usec_timer_pkg::TIMER_BASE_ADDR | {25'h0, off}, prot: 3'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(negedge clk);
            done = s_axi_arready;
            @(posedge clk);
        end
        s_axi_arvalid <= 1'b0;
        done = 1'b0;
        while (!done) begin
            @(negedge clk);
            done = s_axi_rvalid;
            rdata = s_axi_r.data;
            resp = s_axi_r.resp;
            @(posedge clk);
        end
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask : rd

    task rdc(input string name, input logic [6:0] off, input logic [31:0] exp);
        rd(off);
        chk_word(name, exp, rdata);
    endtask : rdc

    // one-cycle tick pulses; adv says whether the count should move
    task ticks(input int n, input bit adv);
        repeat (n) begin
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            @(posedge clk);
        end
        if (adv) cnt = cnt + 64'(n);
    endtask : ticks

    task set_time(input logic [31:0] hi, input logic [31:0] lo);
        wr(usec_timer_pkg::OFF_TIME_LOW_WRITE, lo);
        wr(usec_timer_pkg::OFF_TIME_HIGH_WRITE, hi);
        cnt = {hi, lo};
    endtask : set_time

    task chk_count;
        rdc("live high", usec_timer_pkg::OFF_LIVE_TIME_HIGH, cnt[63:32]);
        rdc("live low", usec_timer_pkg::OFF_LIVE_TIME_LOW, cnt[31:0]);
    endtask : chk_count

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(37513));
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int off = 0; off <= 'h40; off += 4) begin
            rdc("reset value", 7'(off), (off == 'h2C) ? 32'h00000006 : 32'h00000000);
        end
        // staged write, latched pair, carry into the high half
        base = $urandom;
        set_time(base, 32'hFFFFFFFE);
        chk_count();
        wr(usec_timer_pkg::OFF_TIME_LOW_WRITE, $urandom);
        chk_count();
        rdc("latched low", usec_timer_pkg::OFF_TIME_LOW_READ, 32'hFFFFFFFE);
        ticks(3, 1'b1);
        chk_count();
        rdc("latched high", usec_timer_pkg::OFF_TIME_HIGH_READ, base);
        chk_count();
        rdc("pair low", usec_timer_pkg::OFF_TIME_LOW_READ, cnt[31:0]);
        rdc("pair high", usec_timer_pkg::OFF_TIME_HIGH_READ, cnt[63:32]);
        set_time(32'hFFFFFFFF, 32'hFFFFFFFF);
        ticks(1, 1'b1);
        chk_count();
        // freeze bit, then debug halt per processor
        wr(usec_timer_pkg::OFF_TIMER_FREEZE, 32'h00000001);
        ticks(3, 1'b0);
        chk_count();
        wr(usec_timer_pkg::OFF_TIMER_FREEZE, 32'h00000000);
        ticks(2, 1'b1);
        chk_count();
        for (int p = 0; p < 2; p++) begin
            debug_active <= 2'(1 << p);
            ticks(2, 1'b0);
            chk_count();
        end
        wr(usec_timer_pkg::OFF_DEBUG_HALT_ENABLE, 32'h00000002);
        ticks(2, 1'b1);
        chk_count();
        debug_active <= 2'h0;
        wr(usec_timer_pkg::OFF_DEBUG_HALT_ENABLE, 32'h00000006);
        // each alarm: arm, fire once, mask, clear, no refire, early disarm
        for (int i = 0; i < 4; i++) begin
            k = 1 + $urandom_range(7);
            base = $urandom;
            set_time($urandom, base);
            wr(usec_timer_pkg::OFF_IRQ_ENABLE_MASK, onehot(i));
            wr(tgt_off(i), base + k);
            rdc("target", tgt_off(i), base + k);
            rdc("armed", usec_timer_pkg::OFF_ALARM_ARM_STATE, onehot(i));
            ticks(k - 1, 1'b1);
            rdc("raw early", usec_timer_pkg::OFF_IRQ_RAW_FLAGS, 32'h00000000);
            ticks(1, 1'b1);
            rdc("raw fired", usec_timer_pkg::OFF_IRQ_RAW_FLAGS, onehot(i));
            rdc("armed fired", usec_timer_pkg::OFF_ALARM_ARM_STATE, 32'h00000000);
            chk_word("irq line", onehot(i), {28'h0000000, alarm_irq});
            rdc("status", usec_timer_pkg::OFF_IRQ_MASKED_STATUS, onehot(i));
            wr(usec_timer_pkg::OFF_IRQ_ENABLE_MASK, 32'h00000000);
            rdc("status off", usec_timer_pkg::OFF_IRQ_MASKED_STATUS, 32'h00000000);
            chk_word("irq off", 32'h00000000, {28'h0000000, alarm_irq});
            ticks(2, 1'b1);
            rdc("raw held", usec_timer_pkg::OFF_IRQ_RAW_FLAGS, onehot(i));
            wr(usec_timer_pkg::OFF_IRQ_RAW_FLAGS, onehot(i));
            rdc("raw clear", usec_timer_pkg::OFF_IRQ_RAW_FLAGS, 32'h00000000);
            set_time(cnt[63:32], base + k - 1);
            ticks(1, 1'b1);
            rdc("no refire", usec_timer_pkg::OFF_IRQ_RAW_FLAGS, 32'h00000000);
            wr(tgt_off(i), base + k + 2);
            wr(usec_timer_pkg::OFF_ALARM_ARM_STATE, onehot(i));
            rdc("disarmed", usec_timer_pkg::OFF_ALARM_ARM_STATE, 32'h00000000);
            ticks(2, 1'b1);
            rdc("no fire", usec_timer_pkg::OFF_IRQ_RAW_FLAGS, 32'h00000000);
        end
        // force bits reach status and lines without any raw event
        wr(usec_timer_pkg::OFF_IRQ_FORCE_BITS, 32'h00000005);
        rdc("forced", usec_timer_pkg::OFF_IRQ_MASKED_STATUS, 32'h00000005);
        chk_word("forced irq", 32'h00000005, {28'h0000000, alarm_irq});
        wr(usec_timer_pkg::OFF_IRQ_FORCE_BITS, 32'h00000000);
        // past the map and misaligned
        rd(7'h44);
        chk_resp("unmapped read", usec_timer_pkg::RESP_SLVERR, resp);
        wr(7'h46, $urandom);
        chk_resp("misaligned write", usec_timer_pkg::RESP_SLVERR, resp);
        print_verdict();
    end
endmodule : usec_timer_bench

/* File: hw/usec_timer.sv */
/*
 * Microsecond timer: 64-bit counter, four compare alarms, AXI4-Lite slave.
 * Assumes tick is a one-cycle pulse synchronous to clk and that debug
 * activity inputs are synchronous levels.
 */
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module usec_timer (
    input wire logic clk,
    input wire logic reset,
    input wire logic tick,
    input wire logic [1:0] debug_active,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire usec_timer_pkg::axi_addr_type s_axi_aw,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire usec_timer_pkg::axi_wdata_type s_axi_w,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire usec_timer_pkg::axi_addr_type s_axi_ar,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output usec_timer_pkg::axi_rdata_type s_axi_r,
    output logic [3:0] alarm_irq
);

    // ****************************************
    // state
    // ****************************************
    logic [63:0] count_r;
    logic [31:0] low_stage_r;
    logic [31:0] high_latch_r;
    logic [31:0] target_r [4];
    logic [3:0] armed_r;
    logic [3:0] raw_r;
    logic [3:0] enable_r;
    logic [3:0] force_r;
    logic [1:0] dbg_en_r;
    logic freeze_r;
    logic aw_held_r;
    logic w_held_r;
    logic [6:0] aw_off_r;
    logic aw_ok_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    usec_timer_pkg::axi_rdata_type r_r;

    // ****************************************
    // address helpers
    // ****************************************
    // word-aligned offset within the 0x00..0x40 window, else unmapped
    function automatic logic in_map(input logic [31:0] a);
        in_map = (a[31:7] == usec_timer_pkg::TIMER_BASE_ADDR[31:7] || a[31:7] == 25'h0)
            && a[1:0] == 2'h0 && a[6:0] <= usec_timer_pkg::OFF_IRQ_MASKED_STATUS;
    endfunction : in_map

    // byte-enable merge of new data into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction : merge

    // ****************************************
    // write channel decode
    // ****************************************
    wire do_write = aw_held_r && w_held_r && !bvalid_r && aw_ok_r;
    wire write_done = aw_held_r && w_held_r && !bvalid_r;
    wire [31:0] wmask = merge(usec_timer_pkg::WORD_ZERO, 32'hFFFFFFFF, w_strb_r);
    wire wr_high = do_write && aw_off_r == usec_timer_pkg::OFF_TIME_HIGH_WRITE;
    wire wr_low = do_write && aw_off_r == usec_timer_pkg::OFF_TIME_LOW_WRITE;
    wire wr_armed = do_write && aw_off_r == usec_timer_pkg::OFF_ALARM_ARM_STATE;
    wire wr_dbg = do_write && aw_off_r == usec_timer_pkg::OFF_DEBUG_HALT_ENABLE;
    wire wr_frz = do_write && aw_off_r == usec_timer_pkg::OFF_TIMER_FREEZE;
    wire wr_raw = do_write && aw_off_r == usec_timer_pkg::OFF_IRQ_RAW_FLAGS;
    wire wr_en = do_write && aw_off_r == usec_timer_pkg::OFF_IRQ_ENABLE_MASK;
    wire wr_frc = do_write && aw_off_r == usec_timer_pkg::OFF_IRQ_FORCE_BITS;
    wire [3:0] wr_target;
    wire [3:0] clr_bits = w_data_r[3:0] & wmask[3:0];
    // narrow registers merged on the full word so strobes act per byte
    wire [31:0] enable_merged = merge({28'h0000000, enable_r}, w_data_r, w_strb_r);
    wire [31:0] force_merged = merge({28'h0000000, force_r}, w_data_r, w_strb_r);
    wire [1:0] dbg_mask = wmask[usec_timer_pkg::DEBUG_HALT_LSB +: 2];
    wire [1:0] dbg_new = w_data_r[usec_timer_pkg::DEBUG_HALT_LSB +: 2];

    // alarm target strobes by word index 4..7
    for (genvar g = 0; g < 4; g++) begin : g_tgt
        assign wr_target[g] = do_write && aw_off_r[6:2] == 5'(g + 4);
    end

    // ****************************************
    // counter and alarms
    // ****************************************
    // advance gated by tick, freeze and enabled debug halts
    wire halted = freeze_r || |(dbg_en_r & debug_active);
    wire advance = tick && !halted;
    wire [3:0] fire;

    for (genvar g = 0; g < 4; g++) begin : g_fire
        assign fire[g] = armed_r[g] && target_r[g] == count_r[31:0];
    end

    wire [3:0] status = (raw_r & enable_r) | force_r;
    assign alarm_irq = status;

    // counter: a full-word commit wins over a tick in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            count_r <= usec_timer_pkg::COUNT_RESET;
        end else if (wr_high) begin
            count_r <= {merge(count_r[63:32], w_data_r, w_strb_r), low_stage_r};
        end else if (advance) begin
            count_r <= count_r + 64'h0000000000000001;
        end
    end

    // staging store for the low half
    always_ff @(posedge clk) begin
        if (reset) begin
            low_stage_r <= usec_timer_pkg::WORD_ZERO;
        end else if (wr_low) begin
            low_stage_r <= merge(low_stage_r, w_data_r, w_strb_r);
        end
    end

    // alarm targets
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (reset) begin
                target_r[i] <= usec_timer_pkg::WORD_ZERO;
            end else if (wr_target[i]) begin
                target_r[i] <= merge(target_r[i], w_data_r, w_strb_r);
            end
        end
    end

    // armed flags: a fresh arm wins over fire and disarm in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            armed_r <= 4'h0;
        end else begin
            armed_r <= (armed_r & ~fire & ~(wr_armed ? clr_bits : 4'h0)) | wr_target;
        end
    end

    // raw flags: a fire beats a write-one clear
    always_ff @(posedge clk) begin
        if (reset) begin
            raw_r <= 4'h0;
        end else begin
            raw_r <= (raw_r & ~(wr_raw ? clr_bits : 4'h0)) | fire;
        end
    end

    // control registers
    always_ff @(posedge clk) begin
        if (reset) begin
            enable_r <= 4'h0;
            force_r <= 4'h0;
            dbg_en_r <= usec_timer_pkg::DEBUG_HALT_RESET;
            freeze_r <= 1'b0;
        end else begin
            if (wr_en) enable_r <= enable_merged[3:0];
            if (wr_frc) force_r <= force_merged[3:0];
            if (wr_dbg) dbg_en_r <= (dbg_en_r & ~dbg_mask) | (dbg_new & dbg_mask);
            if (wr_frz && w_strb_r[0]) freeze_r <= w_data_r[usec_timer_pkg::FREEZE_BIT];
        end
    end

    // ****************************************
    // write channel handshake
    // ****************************************
    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // address and data taken in either order, response after both
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_off_r <= 7'h00;
            aw_ok_r <= 1'b0;
            w_data_r <= usec_timer_pkg::WORD_ZERO;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= usec_timer_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                aw_off_r <= s_axi_aw.addr[6:0];
                aw_ok_r <= in_map(s_axi_aw.addr);
            end
            if (s_axi_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_w.data;
                w_strb_r <= s_axi_w.strb;
            end
            if (write_done) begin
                bvalid_r <= 1'b1;
                bresp_r <= aw_ok_r ? usec_timer_pkg::RESP_OKAY : usec_timer_pkg::RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    wire [6:0] ar_off = s_axi_ar.addr[6:0];
    wire ar_take = s_axi_arvalid && !rvalid_r;
    wire ar_ok = in_map(s_axi_ar.addr);
    wire rd_low_latched = ar_take && ar_ok && ar_off == usec_timer_pkg::OFF_TIME_LOW_READ;
    logic [31:0] rd_word;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_r = r_r;

    // read mux; write-only registers read as zero
    always_comb begin
        rd_word = usec_timer_pkg::WORD_ZERO;
        unique case (ar_off)
            usec_timer_pkg::OFF_TIME_HIGH_READ: rd_word = high_latch_r;
            usec_timer_pkg::OFF_TIME_LOW_READ: rd_word = count_r[31:0];
            usec_timer_pkg::OFF_ALARM_TARGET_ZERO: rd_word = target_r[0];
            usec_timer_pkg::OFF_ALARM_TARGET_ONE: rd_word = target_r[1];
            usec_timer_pkg::OFF_ALARM_TARGET_TWO: rd_word = target_r[2];
            usec_timer_pkg::OFF_ALARM_TARGET_THREE: rd_word = target_r[3];
            usec_timer_pkg::OFF_ALARM_ARM_STATE: rd_word = {28'h0000000, armed_r};
            usec_timer_pkg::OFF_LIVE_TIME_HIGH: rd_word = count_r[63:32];
            usec_timer_pkg::OFF_LIVE_TIME_LOW: rd_word = count_r[31:0];
            usec_timer_pkg::OFF_DEBUG_HALT_ENABLE: rd_word = {29'h0, dbg_en_r, 1'b0};
            usec_timer_pkg::OFF_TIMER_FREEZE: rd_word = {31'h0, freeze_r};
            usec_timer_pkg::OFF_IRQ_RAW_FLAGS: rd_word = {28'h0000000, raw_r};
            usec_timer_pkg::OFF_IRQ_ENABLE_MASK: rd_word = {28'h0000000, enable_r};
            usec_timer_pkg::OFF_IRQ_FORCE_BITS: rd_word = {28'h0000000, force_r};
            usec_timer_pkg::OFF_IRQ_MASKED_STATUS: rd_word = {28'h0000000, status};
            default: rd_word = usec_timer_pkg::WORD_ZERO;
        endcase
    end

    // upper half caught when the low latched view is read
    always_ff @(posedge clk) begin
        if (reset) begin
            high_latch_r <= usec_timer_pkg::WORD_ZERO;
        end else if (rd_low_latched) begin
            high_latch_r <= count_r[63:32];
        end
    end

    // read data registered, one cycle after the address is taken
    always_ff @(posedge clk) begin
        if (reset) begin
            rvalid_r <= 1'b0;
            r_r <= '0;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            r_r.data <= ar_ok ? rd_word : usec_timer_pkg::WORD_ZERO;
            r_r.resp <= ar_ok ? usec_timer_pkg::RESP_OKAY : usec_timer_pkg::RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    commit_loads_a: assert property (@(posedge clk) disable iff (reset)
        wr_high |=> count_r[31:0] == $past(low_stage_r))
        else $error("high write did not commit staged low half");
    fire_disarms_a: assert property (@(posedge clk) disable iff (reset)
        (fire & ~wr_target) != 4'h0 |=> (armed_r & $past(fire & ~wr_target)) == 4'h0)
        else $error("alarm still armed after firing");
    fire_latches_a: assert property (@(posedge clk) disable iff (reset)
        fire[0] |=> raw_r[0])
        else $error("raw flag missed a fire");
    arm_sets_a: assert property (@(posedge clk) disable iff (reset)
        wr_target[2] |=> armed_r[2])
        else $error("target write did not arm");
    frozen_hold_a: assert property (@(posedge clk) disable iff (reset)
        halted && !wr_high |=> $stable(count_r))
        else $error("count moved while halted");
    tick_step_a: assert property (@(posedge clk) disable iff (reset)
        advance && !wr_high |=> count_r == $past(count_r) + 64'h0000000000000001)
        else $error("count did not step on tick");
    no_tick_a: assert property (@(posedge clk) disable iff (reset)
        !tick && !wr_high |=> $stable(count_r))
        else $error("count moved without tick");
    irq_status_a: assert property (@(posedge clk) disable iff (reset)
        force_r[2] |-> alarm_irq[2])
        else $error("forced alarm interrupt not raised");
    latch_high_a: assert property (@(posedge clk) disable iff (reset)
        rd_low_latched |=> high_latch_r == $past(count_r[63:32]))
        else $error("high half not captured");

    // register writes, reads and bus answers
    disarm_clears_a: assert property (@(posedge clk) disable iff (reset)
        wr_armed |=> (armed_r & $past(clr_bits)) == 4'h0)
        else $error("alarm still armed after disarm write");
    raw_clear_a: assert property (@(posedge clk) disable iff (reset)
        wr_raw && fire == 4'h0 |=> (raw_r & $past(clr_bits)) == 4'h0)
        else $error("raw flag survived its clear");
    stage_hold_a: assert property (@(posedge clk) disable iff (reset)
        wr_low && !advance |=> $stable(count_r))
        else $error("low write reached the count");
    commit_high_a: assert property (@(posedge clk) disable iff (reset)
        wr_high && w_strb_r == 4'hF |=> count_r[63:32] == $past(w_data_r))
        else $error("high write not committed");
    debug_hold_a: assert property (@(posedge clk) disable iff (reset)
        (dbg_en_r & debug_active) != 2'h0 && !wr_high |=> $stable(count_r))
        else $error("count moved in debug halt");
    raw_read_a: assert property (@(posedge clk) disable iff (reset)
        ar_take && ar_off == usec_timer_pkg::OFF_LIVE_TIME_LOW |=> $stable(high_latch_r))
        else $error("live read moved the latch");
    live_high_a: assert property (@(posedge clk) disable iff (reset)
        ar_take && ar_ok && ar_off == usec_timer_pkg::OFF_LIVE_TIME_HIGH
        |=> s_axi_r.data == $past(count_r[63:32]))
        else $error("live high read wrong");
    low_read_a: assert property (@(posedge clk) disable iff (reset)
        ar_take && ar_ok && ar_off == usec_timer_pkg::OFF_TIME_LOW_READ
        |=> s_axi_r.data == $past(count_r[31:0]))
        else $error("latched low read wrong");
    write_slverr_a: assert property (@(posedge clk) disable iff (reset)
        write_done && !aw_ok_r |=> s_axi_bresp == usec_timer_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    read_slverr_a: assert property (@(posedge clk) disable iff (reset)
        ar_take && !ar_ok |=> s_axi_r.resp == usec_timer_pkg::RESP_SLVERR)
        else $error("unmapped read not refused");

    // reset state, watched without the reset disable
    reset_zero_a: assert property (@(posedge clk)
        reset |=> count_r == usec_timer_pkg::COUNT_RESET && armed_r == 4'h0 && raw_r == 4'h0)
        else $error("state not cleared by reset");

endmodule : usec_timer

/* File: include/usec_timer_pkg.sv */
/*
 * Constants, field layouts and bus carrier types for the microsecond timer.
 * Assumes an AXI4-Lite master with 32-bit data and one clock domain.
 */
package usec_timer_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [31:0] TIMER_BASE_ADDR = 32'h40054000;
    localparam logic [6:0] OFF_TIME_HIGH_WRITE = 7'h00;
    localparam logic [6:0] OFF_TIME_LOW_WRITE = 7'h04;
    localparam logic [6:0] OFF_TIME_HIGH_READ = 7'h08;
    localparam logic [6:0] OFF_TIME_LOW_READ = 7'h0C;
    localparam logic [6:0] OFF_ALARM_TARGET_ZERO = 7'h10;
    localparam logic [6:0] OFF_ALARM_TARGET_ONE = 7'h14;
    localparam logic [6:0] OFF_ALARM_TARGET_TWO = 7'h18;
    localparam logic [6:0] OFF_ALARM_TARGET_THREE = 7'h1C;
    localparam logic [6:0] OFF_ALARM_ARM_STATE = 7'h20;
    localparam logic [6:0] OFF_LIVE_TIME_HIGH = 7'h24;
    localparam logic [6:0] OFF_LIVE_TIME_LOW = 7'h28;
    localparam logic [6:0] OFF_DEBUG_HALT_ENABLE = 7'h2C;
    localparam logic [6:0] OFF_TIMER_FREEZE = 7'h30;
    localparam logic [6:0] OFF_IRQ_RAW_FLAGS = 7'h34;
    localparam logic [6:0] OFF_IRQ_ENABLE_MASK = 7'h38;
    localparam logic [6:0] OFF_IRQ_FORCE_BITS = 7'h3C;
    localparam logic [6:0] OFF_IRQ_MASKED_STATUS = 7'h40;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int NUM_ALARMS = 4;
    localparam int DEBUG_HALT_LSB = 1;
    localparam int FREEZE_BIT = 0;
    localparam logic [1:0] DEBUG_HALT_RESET = 2'h3;
    localparam logic [63:0] COUNT_RESET = 64'h0000000000000000;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // bus carriers
    // ****************************************
    typedef struct packed {
        logic [31:0] addr;
        logic [2:0] prot;
    } axi_addr_type;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0] strb;
    } axi_wdata_type;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } axi_rdata_type;

endpackage : usec_timer_pkg
